// *** rtl/bbx_exec.v ***
`include "bbx_exec_regs.vh"

// How it works
// - set-bit forces one, other flags untouched
// - carry form d3, bit-address form d2
// - short jump: signed displacement, -128..+127 reach
// - jump adds two then displacement, two cycles
// - subtract: acc minus source minus carry
// - carry set on borrow from bit seven
// - half-borrow set on borrow from bit three
// - overflow when borrows from six, seven differ
// - subtract forms: register, direct, indirect, immediate
// - nibble swap of accumulator, no flags changed
// - exchange loads acc, stores old acc
// - exchange forms: register, direct, indirect, one cycle
// - digit exchange swaps low nibbles via pointer
// - xor writes destination, flags untouched
// - xor to port reads output latch
// - xor forms, direct-immediate three bytes two cycles
module bbx_exec #(
  parameter MC_CLKS = `BBX_MC_CLKS
)
(
  // clock and reset
  input  wire        i_sys_clk,
  input  wire        i_rst_n,
  // instruction from the fetch unit
  input  wire        i_start,
  input  wire [7:0]  i_opcode,
  input  wire [7:0]  i_byte1,
  input  wire [7:0]  i_byte2,
  input  wire [15:0] i_pc,
  input  wire [1:0]  i_bank_sel,
  // core state loads while idle
  input  wire        i_acc_load,
  input  wire [7:0]  i_acc_in,
  input  wire        i_flag_load,
  input  wire        i_carry_in,
  input  wire        i_half_borrow_in,
  input  wire        i_overflow_in,
  // data memory and special register bus
  output wire        o_mem_rd,
  output wire        o_mem_latch,
  output reg  [7:0]  o_mem_addr,
  output reg         o_mem_ind,
  input  wire [7:0]  i_mem_rdata,
  output reg         o_mem_wr,
  output reg  [7:0]  o_mem_wdata,
  // bit space
  output reg         o_bit_set,
  output reg  [7:0]  o_bit_addr,
  // core state
  output reg  [7:0]  o_acc,
  output reg         o_carry_flag,
  output reg         o_half_borrow_flag,
  output reg         o_signed_overflow_flag,
  // sequencing
  output reg  [15:0] o_pc_next,
  output wire        o_busy,
  output wire        o_done
);

  // --------------------------------------------------------------------------
  // states
  // --------------------------------------------------------------------------
  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_PTR  = 7'h02;
  localparam [6:0] S_PTW  = 7'h04;
  localparam [6:0] S_RD   = 7'h08;
  localparam [6:0] S_RDW  = 7'h10;
  localparam [6:0] S_IMM  = 7'h20;
  localparam [6:0] S_HOLD = 7'h40;
  // clocks per machine cycle, cut to the counter width on purpose
  localparam [7:0] ONE_MC = MC_CLKS[7:0];

  reg  [6:0]  state_q;
  reg  [7:0]  op_q;
  reg  [7:0]  b1_q;
  reg  [7:0]  b2_q;
  reg  [7:0]  cnt_q;
  reg  [7:0]  need_q;
  reg         latch_q;

  // --------------------------------------------------------------------------
  // decode, from the incoming opcode while idle, else from the held one
  // --------------------------------------------------------------------------
  wire        idle_w = state_q[0];
  wire [7:0]  dec_w  = idle_w ? i_opcode : op_q;
  wire [3:0]  hi_w   = dec_w[7:4];
  wire [3:0]  lo_w   = dec_w[3:0];
  wire        lo_reg_w = lo_w[`BBX_LO_REG_BIT];
  wire        lo_dir_w = (lo_w == `BBX_LO_DIRECT);
  wire        lo_ind_w = (lo_w[3:1] == `BBX_LO_INDIRECT);
  wire        lo_imm_w = (lo_w == `BBX_LO_IMMEDIATE);
  wire        src_any_w = lo_reg_w | lo_dir_w | lo_ind_w | lo_imm_w;

  // one flag per instruction group; no two groups share an opcode
  wire f_sub_w     = (hi_w == `BBX_HI_SUB_BORROW) & src_any_w;
  wire f_exch_w    = (hi_w == `BBX_HI_ACC_EXCH) & (lo_reg_w | lo_dir_w | lo_ind_w);
  wire f_nib_w     = (hi_w == `BBX_HI_NIB_EXCH) & lo_ind_w;
  wire f_xor_acc_w = (hi_w == `BBX_HI_EXOR) & src_any_w;
  wire f_xor_da_w  = (dec_w == `BBX_OP_EXOR_DIR_A);
  wire f_xor_di_w  = (dec_w == `BBX_OP_EXOR_DIR_IMM);
  wire f_set_c_w   = (dec_w == `BBX_OP_SET_CARRY);
  wire f_set_bit_w = (dec_w == `BBX_OP_SET_BIT);
  wire f_jump_w    = (dec_w == `BBX_OP_SHORT_JUMP);
  wire f_swap_w    = (dec_w == `BBX_OP_SWAP);

  // operand routing for the multi-form groups
  wire grp_w     = f_sub_w | f_exch_w | f_nib_w | f_xor_acc_w;
  wire use_dir_w = (grp_w & lo_dir_w) | f_xor_da_w | f_xor_di_w;
  wire use_imm_w = (f_sub_w | f_xor_acc_w) & lo_imm_w;
  wire use_reg_w = grp_w & lo_reg_w;
  wire use_ind_w = grp_w & lo_ind_w;

  // bytes and machine cycles of the instruction
  // unknown opcodes fall through as one-byte, one-cycle no-ops
  wire [15:0] len_w = f_xor_di_w ? 16'h0003 :
                      (use_dir_w | use_imm_w | f_set_bit_w | f_jump_w) ? 16'h0002 :
                      16'h0001;
  wire        two_mc_w = f_jump_w | f_xor_di_w;

  // register bank addresses formed from the bank select
  wire [7:0] bank_register_selected_addr    = {3'b000, i_bank_sel, lo_w[2:0]};
  wire [7:0] pointer_register_selected_addr = {3'b000, i_bank_sel, 2'b00, lo_w[0]};

  // --------------------------------------------------------------------------
  // datapath helpers
  // --------------------------------------------------------------------------
  wire [15:0] jump_target_w;
  wire [7:0]  src_w = state_q[5] ? b1_q : i_mem_rdata;
  wire [7:0]  diff_w;
  wire        sub_carry_w;
  wire        sub_half_w;
  wire        sub_ovf_w;

  bbx_rel_target u_rel
  (
    .i_pc     (i_pc),
    .i_rel    (i_byte1),
    .o_target (jump_target_w)
  );

  bbx_sub_alu u_sub
  (
    .i_minuend     (o_acc),
    .i_subtrahend  (src_w),
    .i_borrow_in   (o_carry_flag),
    .o_diff        (diff_w),
    .o_carry       (sub_carry_w),
    .o_half_borrow (sub_half_w),
    .o_overflow    (sub_ovf_w)
  );

  // --------------------------------------------------------------------------
  // bus strobes and completion
  // --------------------------------------------------------------------------
  // reads are issued in the two issue states; data returns one clock later
  assign o_mem_rd    = state_q[1] | state_q[3];
  assign o_mem_latch = state_q[3] & latch_q;
  assign o_busy      = ~idle_w;
  assign o_done      = state_q[6] & (cnt_q >= need_q);

  // --------------------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------------------
  // the cycle count runs from the accepting edge, so the longest (indirect) path
  // must fit in one machine cycle: MC_CLKS of at least 5
  always @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_q <= S_IDLE;
      op_q    <= `BBX_RST_BYTE;
      b1_q    <= `BBX_RST_BYTE;
      b2_q    <= `BBX_RST_BYTE;
      cnt_q   <= 8'h00;
      need_q  <= 8'h00;
      latch_q <= 1'b0;
    end
    else
    begin
      cnt_q <= idle_w ? 8'h00 : cnt_q + 8'h01;
      case (state_q)
        S_IDLE:
        begin
          if (i_start)
          begin
            op_q    <= i_opcode;
            b1_q    <= i_byte1;
            b2_q    <= i_byte2;
            need_q  <= two_mc_w ? (ONE_MC + ONE_MC - 8'h01) : (ONE_MC - 8'h01);
            // a port as xor destination must read its latch, not its pins
            latch_q <= f_xor_da_w | f_xor_di_w;
            if (use_ind_w)
              state_q <= S_PTR;
            else if (use_reg_w | use_dir_w)
              state_q <= S_RD;
            else if (use_imm_w)
              state_q <= S_IMM;
            else
              state_q <= S_HOLD;
          end
        end
        S_PTR:   state_q <= S_PTW;
        S_PTW:   state_q <= S_RD;
        S_RD:    state_q <= S_RDW;
        S_RDW:   state_q <= S_HOLD;
        S_IMM:   state_q <= S_HOLD;
        S_HOLD:
        begin
          if (cnt_q >= need_q)
            state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // bus address, write strobe and bit strobe
  // --------------------------------------------------------------------------
  always @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_mem_addr  <= `BBX_RST_BYTE;
      o_mem_ind   <= 1'b0;
      o_mem_wr    <= 1'b0;
      o_mem_wdata <= `BBX_RST_BYTE;
      o_bit_set   <= 1'b0;
      o_bit_addr  <= `BBX_RST_BYTE;
    end
    else
    begin
      o_mem_wr  <= 1'b0;
      o_bit_set <= 1'b0;
      if (idle_w & i_start)
      begin
        o_mem_ind <= 1'b0;
        if (use_ind_w)
          o_mem_addr <= pointer_register_selected_addr;
        else if (use_reg_w)
          o_mem_addr <= bank_register_selected_addr;
        else if (use_dir_w)
          o_mem_addr <= i_byte1;
        if (f_set_bit_w)
        begin
          o_bit_addr <= i_byte1;
          o_bit_set  <= 1'b1;
        end
      end
      // pointer value becomes the indirect address
      if (state_q[2])
      begin
        o_mem_addr <= i_mem_rdata;
        o_mem_ind  <= 1'b1;
      end
      // write-back of the operand location, same address as the read
      if (state_q[4])
      begin
        // exchange stores the accumulator held before this edge
        if (f_exch_w)
        begin
          o_mem_wr    <= 1'b1;
          o_mem_wdata <= o_acc;
        end
        else if (f_nib_w)
        begin
          o_mem_wr    <= 1'b1;
          o_mem_wdata <= {i_mem_rdata[7:4], o_acc[3:0]};
        end
        else if (f_xor_da_w)
        begin
          o_mem_wr    <= 1'b1;
          o_mem_wdata <= i_mem_rdata ^ o_acc;
        end
        else if (f_xor_di_w)
        begin
          o_mem_wr    <= 1'b1;
          o_mem_wdata <= i_mem_rdata ^ b2_q;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // accumulator and flags
  // --------------------------------------------------------------------------
  // only subtract and set-carry touch the flags; everything else leaves them alone
  always @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_acc                  <= `BBX_RST_BYTE;
      o_carry_flag           <= 1'b0;
      o_half_borrow_flag     <= 1'b0;
      o_signed_overflow_flag <= 1'b0;
    end
    else if (idle_w)
    begin
      // set-carry wins over a flag load in the same cycle
      if (i_start & f_set_c_w)
        o_carry_flag <= 1'b1;
      else if (i_flag_load)
        o_carry_flag <= i_carry_in;
      if (i_flag_load)
      begin
        o_half_borrow_flag     <= i_half_borrow_in;
        o_signed_overflow_flag <= i_overflow_in;
      end
      if (i_start & f_swap_w)
        o_acc <= {o_acc[3:0], o_acc[7:4]};
      else if (i_acc_load)
        o_acc <= i_acc_in;
    end
    else if (state_q[4] | state_q[5])
    begin
      if (f_sub_w)
      begin
        o_acc                  <= diff_w;
        o_carry_flag           <= sub_carry_w;
        o_half_borrow_flag     <= sub_half_w;
        o_signed_overflow_flag <= sub_ovf_w;
      end
      else if (f_exch_w)
        o_acc <= src_w;
      else if (f_nib_w)
        o_acc <= {o_acc[7:4], src_w[3:0]};
      else if (f_xor_acc_w)
        o_acc <= o_acc ^ src_w;
    end
  end

  // --------------------------------------------------------------------------
  // next program counter, latched at acceptance
  // --------------------------------------------------------------------------
  always @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_pc_next <= `BBX_RST_PC;
    else if (idle_w & i_start)
      o_pc_next <= f_jump_w ? jump_target_w : (i_pc + len_w);
  end

endmodule

// *** rtl/bbx_exec_regs.vh ***
`ifndef BBX_EXEC_REGS_VH
`define BBX_EXEC_REGS_VH

// ----------------------------------------------------------------------------
// opcodes of the single-form instructions
// ----------------------------------------------------------------------------
`define BBX_OP_SET_CARRY    8'hd3
`define BBX_OP_SET_BIT      8'hd2
`define BBX_OP_SHORT_JUMP   8'h80
`define BBX_OP_SWAP         8'hc4
`define BBX_OP_EXOR_DIR_A   8'h62
`define BBX_OP_EXOR_DIR_IMM 8'h63

// ----------------------------------------------------------------------------
// high nibbles of the operand-form groups
// ----------------------------------------------------------------------------
`define BBX_HI_SUB_BORROW  4'h9
`define BBX_HI_ACC_EXCH    4'hc
`define BBX_HI_NIB_EXCH    4'hd
`define BBX_HI_EXOR        4'h6

// ----------------------------------------------------------------------------
// low nibble operand forms
// ----------------------------------------------------------------------------
`define BBX_LO_DIRECT      4'h5
`define BBX_LO_IMMEDIATE   4'h4
`define BBX_LO_INDIRECT    3'b011
`define BBX_LO_REG_BIT     3

// ----------------------------------------------------------------------------
// timing and reset values
// ----------------------------------------------------------------------------
`define BBX_MC_CLKS        6
`define BBX_JUMP_ADVANCE   16'h0002
`define BBX_RST_BYTE       8'h00
`define BBX_RST_PC         16'h0000

`endif

// *** rtl/bbx_rel_target.v ***
`include "bbx_exec_regs.vh"

// ----------------------------------------------------------------------------
// short jump destination
// ----------------------------------------------------------------------------
module bbx_rel_target
(
  // instruction address and displacement byte
  input  wire [15:0] i_pc,
  input  wire [7:0]  i_rel,
  // destination
  output wire [15:0] o_target
);

  wire [15:0] advanced_w;

  // step past both bytes first, then add the sign-extended offset
  assign advanced_w = i_pc + `BBX_JUMP_ADVANCE;
  assign o_target   = advanced_w + {{8{i_rel[7]}}, i_rel};

endmodule

// *** rtl/bbx_sub_alu.v ***
`include "bbx_exec_regs.vh"

// ----------------------------------------------------------------------------
// subtract with borrow and its three flags
// ----------------------------------------------------------------------------
module bbx_sub_alu
(
  // operands
  input  wire [7:0] i_minuend,
  input  wire [7:0] i_subtrahend,
  input  wire       i_borrow_in,
  // result
  output wire [7:0] o_diff,
  output wire       o_carry,
  output wire       o_half_borrow,
  output wire       o_overflow
);

  wire [8:0] full_w;
  wire [7:0] low7_w;
  wire [4:0] low4_w;

  // three widths of the same difference expose each borrow
  assign full_w = {1'b0, i_minuend} - {1'b0, i_subtrahend} - {8'h00, i_borrow_in};
  assign low7_w = {1'b0, i_minuend[6:0]} - {1'b0, i_subtrahend[6:0]} - {7'h00, i_borrow_in};
  assign low4_w = {1'b0, i_minuend[3:0]} - {1'b0, i_subtrahend[3:0]} - {4'h0, i_borrow_in};

  assign o_diff        = full_w[7:0];
  assign o_carry       = full_w[8];
  assign o_half_borrow = low4_w[4];
  assign o_overflow    = low7_w[7] ^ full_w[8];

endmodule

// *** tb/bbx_exec_properties.sv ***
module bbx_exec_props #(
  parameter MC_CLKS = 6
)
(
  input wire        i_sys_clk,
  input wire        i_rst_n,
  input wire        i_start,
  input wire [7:0]  i_opcode,
  input wire [7:0]  i_byte1,
  input wire [15:0] i_pc,
  input wire        o_mem_rd,
  input wire        o_mem_latch,
  input wire        o_bit_set,
  input wire [7:0]  o_bit_addr,
  input wire [7:0]  o_acc,
  input wire        o_carry_flag,
  input wire        o_half_borrow_flag,
  input wire        o_signed_overflow_flag,
  input wire [15:0] o_pc_next,
  input wire        o_busy,
  input wire        o_done
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  // ---------------------------------------------------------------
  // cycle count since accept; cycle one is the one after the edge
  // ---------------------------------------------------------------
  wire      take = i_start && !o_busy;
  reg [4:0] cyc_q;
  reg       two_q;
  always @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n) cyc_q <= 5'h00;
    else if (take) cyc_q <= 5'h01;
    else if (cyc_q != 5'h1f) cyc_q <= cyc_q + 5'h01;
  end
  // long forms latched at accept
  always @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n) two_q <= 1'b0;
    else if (take) two_q <= (i_opcode == 8'h80) || (i_opcode == 8'h63);
  end
  wire [2:0] fl = {o_carry_flag, o_half_borrow_flag, o_signed_overflow_flag};
  AST_DONE_TIME: assert property (
    o_done |-> cyc_q == MC_CLKS * (two_q ? 2 : 1))
    else $error("done at wrong cycle");
  AST_JUMP_TARGET: assert property (
    take && i_opcode == 8'h80 |=> o_pc_next ==
      $past(i_pc) + 16'h0002 + {{8{$past(i_byte1[7])}}, $past(i_byte1)})
    else $error("jump target wrong");
  AST_SET_CARRY: assert property (
    take && i_opcode == 8'hd3 |=> o_carry_flag && $stable(o_half_borrow_flag)
      && $stable(o_signed_overflow_flag))
    else $error("carry set wrong");
  AST_SET_BIT: assert property (
    take && i_opcode == 8'hd2 |=> o_bit_set && o_bit_addr == $past(i_byte1))
    else $error("bit set wrong");
  AST_SWAP: assert property (
    take && i_opcode == 8'hc4 |=> o_acc == {$past(o_acc[3:0]), $past(o_acc[7:4])}
      && $stable(fl))
    else $error("swap wrong");
  AST_SUB_IMM: assert property (
    take && i_opcode == 8'h94 |=> ##1 o_acc ==
      $past(o_acc, 2) - $past(i_byte1, 2) - {7'h00, $past(o_carry_flag, 2)})
    else $error("subtract immediate wrong");
  AST_XOR_IMM: assert property (
    take && i_opcode == 8'h64 |=> ##1 o_acc == ($past(o_acc, 2) ^ $past(i_byte1, 2))
      && fl == $past(fl, 2))
    else $error("xor immediate wrong");
  AST_XOR_LATCH: assert property (
    take && (i_opcode == 8'h62 || i_opcode == 8'h63) |=> o_mem_rd && o_mem_latch)
    else $error("port latch not read");
endmodule

bind bbx_exec bbx_exec_props #(.MC_CLKS(MC_CLKS)) u_props (.i_sys_clk(i_sys_clk),
  .i_rst_n(i_rst_n), .i_start(i_start), .i_opcode(i_opcode), .i_byte1(i_byte1),
  .i_pc(i_pc), .o_mem_rd(o_mem_rd), .o_mem_latch(o_mem_latch), .o_bit_set(o_bit_set),
  .o_bit_addr(o_bit_addr), .o_acc(o_acc), .o_carry_flag(o_carry_flag),
  .o_half_borrow_flag(o_half_borrow_flag), .o_pc_next(o_pc_next),
  .o_signed_overflow_flag(o_signed_overflow_flag), .o_busy(o_busy), .o_done(o_done));

// *** tb/bbx_exec_test.sv ***
module bbx_exec_test;
  timeunit 1ns;
  timeprecision 1ps;
  reg        i_sys_clk = 1'b0, i_rst_n = 1'b0, i_start = 1'b0;
  reg [7:0]  i_opcode = 8'h00, i_byte1 = 8'h00, i_byte2 = 8'h00;
  reg [15:0] i_pc = 16'h0000;
  reg [1:0]  i_bank_sel = 2'h0;
  reg        i_acc_load = 1'b0, i_flag_load = 1'b0, i_carry_in = 1'b0;
  reg [7:0]  i_acc_in = 8'h00, i_mem_rdata = 8'h00;
  reg        i_half_borrow_in = 1'b0, i_overflow_in = 1'b0;
  wire       o_mem_rd, o_mem_latch, o_mem_ind, o_mem_wr, o_bit_set, o_busy, o_done;
  wire [7:0] o_mem_addr, o_mem_wdata, o_bit_addr, o_acc;
  wire       o_carry_flag, o_half_borrow_flag, o_signed_overflow_flag;
  wire [15:0] o_pc_next;
  reg [7:0]  mem [0:255];
  reg        wr_ind = 1'b0;
  reg [7:0]  bit_seen = 8'h00, bit_cnt = 8'h00;
  integer    failures = 0, n_compared = 0;
  always #4 i_sys_clk = ~i_sys_clk;
  bbx_exec DUT (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_start(i_start),
    .i_opcode(i_opcode), .i_byte1(i_byte1), .i_byte2(i_byte2), .i_pc(i_pc),
    .i_bank_sel(i_bank_sel), .i_acc_load(i_acc_load), .i_acc_in(i_acc_in),
    .i_flag_load(i_flag_load), .i_carry_in(i_carry_in), .o_mem_ind(o_mem_ind),
    .i_half_borrow_in(i_half_borrow_in), .i_overflow_in(i_overflow_in),
    .o_mem_rd(o_mem_rd), .o_mem_latch(o_mem_latch), .o_mem_addr(o_mem_addr),
    .i_mem_rdata(i_mem_rdata), .o_mem_wr(o_mem_wr), .o_mem_wdata(o_mem_wdata),
    .o_bit_set(o_bit_set), .o_bit_addr(o_bit_addr), .o_acc(o_acc),
    .o_carry_flag(o_carry_flag), .o_half_borrow_flag(o_half_borrow_flag),
    .o_signed_overflow_flag(o_signed_overflow_flag), .o_pc_next(o_pc_next),
    .o_busy(o_busy), .o_done(o_done));
  // ---------------------------------------------------------------
  // memory model: one space, data one clock after the read strobe
  // ---------------------------------------------------------------
  // port at 0x90 shows pin level 0xee unless its latch is asked for
  always @(posedge i_sys_clk)
  begin
    if (o_mem_rd && !o_mem_latch && o_mem_addr == 8'h90) i_mem_rdata <= 8'hee;
    else if (o_mem_rd) i_mem_rdata <= mem[o_mem_addr];
    else i_mem_rdata <= ~i_mem_rdata; // no stale data between reads
    if (o_mem_wr) mem[o_mem_addr] <= o_mem_wdata;
    if (o_mem_wr) wr_ind <= o_mem_ind;
    if (o_bit_set) bit_seen <= o_bit_addr;
    if (o_bit_set) bit_cnt <= bit_cnt + 8'h01;
  end
  task chk(input [15:0] got, input [15:0] exp);
  begin
    n_compared = n_compared + 1;
    if (got !== exp)
    begin
      failures = failures + 1;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  end
  endtask
  // load accumulator and flags while idle
  task ld(input [7:0] a, input c, input h, input v);
  begin
    i_acc_load <= 1'b1;
    i_acc_in <= a;
    i_flag_load <= 1'b1;
    i_carry_in <= c;
    i_half_borrow_in <= h;
    i_overflow_in <= v;
    @(posedge i_sys_clk);
    i_acc_load <= 1'b0;
    i_flag_load <= 1'b0;
  end
  endtask
  // issue one instruction, count cycles up to done
  task run(input [7:0] op, input [7:0] b1, input [7:0] b2, input integer mcs);
    integer n;
  begin
    i_opcode <= op;
    i_byte1 <= b1;
    i_byte2 <= b2;
    i_start <= 1'b1;
    @(posedge i_sys_clk);
    i_start <= 1'b0;
    n = 1;
    #1;
    chk(o_busy, 1'b1);
    while (o_done !== 1'b1 && n < 40)
    begin
      @(posedge i_sys_clk);
      #1 n = n + 1;
    end
    chk(n, 6 * mcs);
    @(posedge i_sys_clk);
  end
  endtask
  task t_subtract_borrow_op;
  begin
    ld(8'hc9, 1'b1, 1'b0, 1'b0);
    mem[2] = 8'h54;
    run(8'h9a, 8'h00, 8'h00, 1);
    chk(o_acc, 8'h74);
    chk({o_carry_flag, o_half_borrow_flag, o_signed_overflow_flag}, 3'b001);
    run(8'h94, 8'h75, 8'h00, 1);
    chk(o_acc, 8'hff);
    chk({o_carry_flag, o_half_borrow_flag, o_signed_overflow_flag}, 3'b110);
    i_bank_sel <= 2'h1;
    mem[8] = 8'h30;
    mem[8'h30] = 8'h0f;
    run(8'h96, 8'h00, 8'h00, 1);
    chk({o_acc, o_carry_flag, o_half_borrow_flag}, 10'h3bd);
    mem[8'h40] = 8'h70;
    run(8'h95, 8'h40, 8'h00, 1);
    chk({o_acc, o_carry_flag, o_half_borrow_flag, o_signed_overflow_flag}, 11'h3f9);
    i_bank_sel <= 2'h0;
  end
  endtask
  task t_jump;
  begin
    i_pc <= 16'h0100;
    run(8'h80, 8'h21, 8'h00, 2);
    chk(o_pc_next, 16'h0123);
    run(8'h80, 8'h80, 8'h00, 2);
    chk(o_pc_next, 16'h0082);
    run(8'h80, 8'hfe, 8'h00, 2);
    chk(o_pc_next, 16'h0100);
  end
  endtask
  task t_bits_swap;
  begin
    ld(8'hc5, 1'b0, 1'b1, 1'b0);
    run(8'hd3, 8'h00, 8'h00, 1);
    chk({o_carry_flag, o_half_borrow_flag, o_signed_overflow_flag}, 3'b110);
    run(8'hd2, 8'h91, 8'h00, 1);
    chk({bit_cnt, bit_seen}, 16'h0191);
    run(8'hc4, 8'h00, 8'h00, 1);
    chk(o_acc, 8'h5c);
    chk({o_carry_flag, o_half_borrow_flag, o_signed_overflow_flag}, 3'b110);
  end
  endtask
  task t_xch;
  begin
    ld(8'h3f, 1'b0, 1'b0, 1'b1);
    mem[0] = 8'h20;
    mem[8'h20] = 8'h75;
    run(8'hc6, 8'h00, 8'h00, 1);
    chk({o_acc, mem[8'h20]}, 16'h753f);
    chk(wr_ind, 1'b1);
    mem[1] = 8'ha5;
    run(8'hc9, 8'h00, 8'h00, 1);
    chk({o_acc, mem[1]}, 16'ha575);
    mem[8'h50] = 8'h12;
    run(8'hc5, 8'h50, 8'h00, 1);
    chk({o_acc, mem[8'h50]}, 16'h12a5);
    chk(wr_ind, 1'b0);
    ld(8'h36, 1'b0, 1'b0, 1'b1);
    mem[8'h20] = 8'h75;
    run(8'hd6, 8'h00, 8'h00, 1);
    chk({o_acc, mem[8'h20]}, 16'h3576);
    chk(o_signed_overflow_flag, 1'b1);
  end
  endtask
  task t_xrl;
  begin
    ld(8'hc3, 1'b1, 1'b0, 1'b0);
    mem[0] = 8'haa;
    run(8'h68, 8'h00, 8'h00, 1);
    chk(o_acc, 8'h69);
    mem[8'h90] = 8'h34;
    run(8'h63, 8'h90, 8'h31, 2);
    chk(mem[8'h90], 8'h05);
    run(8'h62, 8'h90, 8'h00, 1);
    chk(mem[8'h90], 8'h6c);
    run(8'h64, 8'hff, 8'h00, 1);
    chk(o_acc, 8'h96);
    chk(o_carry_flag, 1'b1);
    run(8'h65, 8'h90, 8'h00, 1);
    chk(o_acc, 8'h78);
    mem[1] = 8'h0f;
    mem[8'h0f] = 8'h3c;
    run(8'h67, 8'h00, 8'h00, 1);
    chk(o_acc, 8'h44);
  end
  endtask
  task give_verdict;
  begin
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask
  // watchdog well past the whole sequence
  initial
  begin
    #20000;
    failures = failures + 1;
    give_verdict;
  end
  initial
  begin
    repeat (4) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    @(posedge i_sys_clk);
    t_subtract_borrow_op;
    t_jump;
    t_bits_swap;
    t_xch;
    t_xrl;
    give_verdict;
  end
endmodule
